// ==== logic/io_cell_consts.svh ====
// register offsets, field positions and reset values of the io cell
`ifndef IO_CELL_CONSTS_SVH
`define IO_CELL_CONSTS_SVH

// byte addresses of the register words
`define CELL_CFG_OFS      8'h00
`define CELL_STAT_OFS     8'h04
`define CELL_ADR_W        8

// configuration word fields
`define CFG_CODE_LSB      0
`define CFG_CODE_MSB      5
`define CFG_POL_BIT       8
`define CFG_MULT_LSB      9
`define CFG_MULT_MSB      10
`define CFG_GATE_BIT      12

// reset values: input-only registered pad, rising edges, x1, gate open
`define CFG_CODE_RST      6'h00
`define CFG_POL_RST       1'h0
`define CFG_MULT_RST      2'h0
`define CFG_GATE_RST      1'h0

// status word fields
`define STAT_IN0_BIT      0
`define STAT_IN1_BIT      1
`define STAT_OE_BIT       2
`define STAT_OUT_BIT      3
`define STAT_PHASE_BIT    4
`define STAT_MULT_OK_BIT  5

// number of replicated pad drivers at most
`define PAD_LANES         3
`define MULT_X2           2'h2
`define MULT_X3           2'h3
`endif

// ==== logic/io_cell_pkg.sv ====
// types shared by the io cell and its bench
package io_cell_pkg;
    // input behaviour, low two bits of the function code
    typedef enum logic [1:0] {
        IN_REG      = 2'b00,
        IN_COMB     = 2'b01,
        IN_REG_HOLD = 2'b10,
        IN_HOLD     = 2'b11
    } in_mode_t;

    // output data path, bits 3:2 of the function code
    typedef enum logic [1:0] {
        DM_DDR  = 2'b00,
        DM_REG  = 2'b01,
        DM_COMB = 2'b10,
        DM_INV  = 2'b11
    } data_mode_t;

    // output drive control, bits 5:4 of the function code
    typedef enum logic [1:0] {
        DRV_NONE   = 2'b00,
        DRV_ALWAYS = 2'b01,
        DRV_EN     = 2'b10,
        DRV_REGEN  = 2'b11
    } drive_mode_t;

    // fabric signals into the cell
    typedef struct packed {
        logic d_out_0;   // data after the first launch edge
        logic d_out_1;   // data after the second launch edge
        logic out_en;    // drive control, high drives
        logic in_hold;   // input hold control
        logic clk_gate;  // shared clock gate
    } fabric_to_cell_t;

    // cell signals back to the fabric
    typedef struct packed {
        logic d_in_0;    // first-edge or direct input
        logic d_in_1;    // second-edge input
    } cell_to_fabric_t;
endpackage : io_cell_pkg

// ==== logic/configurable_io_cell.sv ====
// configurable pad cell with wishbone configuration port
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`include "io_cell_consts.svh"
// What this block does
// - six-bit code: low input, high output
// - code 01 passes pad straight through
// - code 11 holds input while hold asserted
// - code 00 registers pad on capture edge
// - code 10 registers, frozen while hold high
// - ddr input: first edge d0, second d1
// - output code 0000 never drives pad
// - 0110/1010/1110 drive data unregistered
// - 0101/1001/1101 drive launch-registered data
// - ddr output: d0 first edge, d1 second
// - 0111/1011/1111 drive inverted registered data
// - code 100000 gives full ddr cell
// - default code 000000, registered input only
// - polarity option flips every flip-flop edge
// - one gate, capture and launch clocks
// - unused gate means always enabled
// - x2/x3 replicate any driving registered-data pad
// - global variant buffers pad input
// - standalone buffer forwards fabric signal
module configurable_io_cell (
    // system
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    // wishbone slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [`CELL_ADR_W-1:0]       wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    // cell clocks, sampled as levels
    input  wire logic                         capture_clk,
    input  wire logic                         launch_clk,
    // fabric side
    input  wire io_cell_pkg::fabric_to_cell_t fabric_i,
    output io_cell_pkg::cell_to_fabric_t      fabric_o,
    // global buffers
    input  wire logic                         fabric_signal_in,
    output logic                              gbuf_pad_out,
    output logic                              gbuf_fabric_out,
    // package pin, one driver per replica
    input  wire logic                         pad_in,
    output logic      [`PAD_LANES-1:0]        pad_out,
    output logic      [`PAD_LANES-1:0]        pad_oe
);
    import io_cell_pkg::*;

    // configuration registers
    logic [5:0]            code_ff;      // function code
    logic                  pol_ff;       // edge polarity option
    logic [1:0]            mult_ff;      // drive multiplier
    logic                  gate_used_ff; // gate treated as connected

    // bus answer
    logic                  ack_ff;
    logic [31:0]           rdat_ff;

    // clock level history for edge detection
    logic                  cap_prev_ff;
    logic                  lau_prev_ff;

    // input side flops
    logic                  in0_ff;
    logic                  in1_ff;

    // launch side flops
    logic                  out0_ff;
    logic                  out1_ff;
    logic                  oe_reg_ff;
    logic                  phase_ff;     // high after first launch edge

    // pad and buffer flops
    logic [`PAD_LANES-1:0] pad_out_ff;
    logic [`PAD_LANES-1:0] pad_oe_ff;
    logic                  gb_pad_ff;
    logic                  gb_fab_ff;

    // function code map:
    //   bits 1:0 input path
    //     00 registered, second flop for ddr
    //     01 pad passed straight through
    //     10 registered, frozen by hold
    //     11 pad followed, held by hold
    //   bits 3:2 output data path
    //     00 ddr, d0 then d1
    //     01 d0 registered on launch
    //     10 d0 passed straight through
    //     11 d0 registered and inverted
    //   bits 5:4 drive: 00 never, 01 always,
    //     10 enable, 11 enable registered
    // decoded fields
    in_mode_t              in_mode;
    data_mode_t            data_mode;
    drive_mode_t           drive_mode;

    wire [1:0] in_bits   = code_ff[1:0];
    wire [1:0] dm_bits   = code_ff[3:2];
    wire [1:0] drv_bits  = code_ff[5:4];
    assign in_mode    = in_mode_t'(in_bits);
    assign data_mode  = data_mode_t'(dm_bits);
    assign drive_mode = drive_mode_t'(drv_bits);


    // a request is taken once; the ack flop blocks a
    // second take while the master still holds stb
    // bus decode
    wire       bus_req   = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire       bus_wr    = bus_req & wb_we_i;
    wire       sel_cfg   = (wb_adr_i == `CELL_CFG_OFS);
    wire       sel_stat  = (wb_adr_i == `CELL_STAT_OFS);
    wire       wr_cfg_b0 = bus_wr & sel_cfg & wb_sel_i[0];
    wire       wr_cfg_b1 = bus_wr & sel_cfg & wb_sel_i[1];

    // clocks are sampled levels: each level must last
    // a system clock, and a clock high at release
    // counts as a rising edge
    // raw clock edges
    wire cap_rise = capture_clk & ~cap_prev_ff;
    wire cap_fall = ~capture_clk & cap_prev_ff;
    wire lau_rise = launch_clk & ~lau_prev_ff;
    wire lau_fall = ~launch_clk & lau_prev_ff;

    // active edges after polarity; first edge is the "rising" one
    // polarity 1 moves every flop to the other edge
    wire cap_pri  = pol_ff ? cap_fall : cap_rise;
    wire cap_sec  = pol_ff ? cap_rise : cap_fall;
    wire lau_pri  = pol_ff ? lau_fall : lau_rise;
    wire lau_sec  = pol_ff ? lau_rise : lau_fall;

    // shared gate, open when not marked as connected
    // a gate left unconnected must never stop the cell
    wire gate_on  = ~gate_used_ff | fabric_i.clk_gate;
    wire cap_en0  = gate_on & cap_pri;
    wire cap_en1  = gate_on & cap_sec;
    wire lau_en0  = gate_on & lau_pri;
    wire lau_en1  = gate_on & lau_sec;

    // replication only for registered-data pads that drive
    // every other mode keeps lane 0 alone
    wire mult_ok  = (data_mode == DM_REG) &&
                    (drive_mode != DRV_NONE);

    // next values
    logic                  nxt_in0;
    logic                  nxt_in1;
    logic                  nxt_data;
    logic                  nxt_drive;
    logic [`PAD_LANES-1:0] lane_mask;
    logic [31:0]           nxt_rdat;

    // input path selection
    // flops keep their value unless a branch loads them
    always_comb begin
        nxt_in0 = in0_ff;
        nxt_in1 = in1_ff;
        case (in_mode)
            IN_COMB: begin
                nxt_in0 = pad_in;
            end
            IN_HOLD: begin
                // keep last value while hold is high
                if (!fabric_i.in_hold) begin
                    nxt_in0 = pad_in;
                end
            end
            IN_REG: begin
                // both edges captured, ddr when d_in_1 used
                if (cap_en0) begin
                    nxt_in0 = pad_in;
                end
                if (cap_en1) begin
                    nxt_in1 = pad_in;
                end
            end
            IN_REG_HOLD: begin
                // register frozen while hold is high
                if (!fabric_i.in_hold && cap_en0) begin
                    nxt_in0 = pad_in;
                end
                if (!fabric_i.in_hold && cap_en1) begin
                    nxt_in1 = pad_in;
                end
            end
            default: begin
                nxt_in0 = in0_ff;
            end
        endcase
    end

    // output data selection
    // inverted data still waits for its launch edge
    always_comb begin
        case (data_mode)
            DM_COMB: nxt_data = fabric_i.d_out_0;
            DM_REG:  nxt_data = out0_ff;
            DM_DDR: begin
                // first half after first edge, second after next
                nxt_data = phase_ff ? out0_ff : out1_ff;
            end
            DM_INV:  nxt_data = ~out0_ff;
            default: nxt_data = 1'h0;
        endcase
    end

    // drive control selection
    // codes 00xx never drive, whatever the data
    always_comb begin
        case (drive_mode)
            DRV_NONE:   nxt_drive = 1'h0;
            DRV_ALWAYS: nxt_drive = 1'h1;
            DRV_EN:     nxt_drive = fabric_i.out_en;
            DRV_REGEN:  nxt_drive = oe_reg_ff;
            default:    nxt_drive = 1'h0;
        endcase
    end

    // a disabled replica floats and shows zero, so the
    // pin sees only the lanes that really drive
    // which replicas drive
    always_comb begin
        lane_mask = 3'h1;
        if (mult_ok && mult_ff == `MULT_X2) begin
            lane_mask = 3'h3;
        end else if (mult_ok && mult_ff == `MULT_X3) begin
            lane_mask = 3'h7;
        end
    end

    // read data mux
    // unmapped places read zero
    always_comb begin
        nxt_rdat = 32'h0;
        if (sel_cfg) begin
            nxt_rdat[`CFG_CODE_MSB:`CFG_CODE_LSB] = code_ff;
            nxt_rdat[`CFG_POL_BIT]                = pol_ff;
            nxt_rdat[`CFG_MULT_MSB:`CFG_MULT_LSB] = mult_ff;
            nxt_rdat[`CFG_GATE_BIT]               = gate_used_ff;
        end else if (sel_stat) begin
            nxt_rdat[`STAT_IN0_BIT]     = in0_ff;
            nxt_rdat[`STAT_IN1_BIT]     = in1_ff;
            nxt_rdat[`STAT_OE_BIT]      = pad_oe_ff[0];
            nxt_rdat[`STAT_OUT_BIT]     = pad_out_ff[0];
            nxt_rdat[`STAT_PHASE_BIT]   = phase_ff;
            nxt_rdat[`STAT_MULT_OK_BIT] = mult_ok;
        end
    end

    // bus answer, one cycle after the request
    // read data stands only in the ack cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack_ff  <= 1'h0;
            rdat_ff <= 32'h0;
        end else begin
            ack_ff  <= bus_req;
            rdat_ff <= bus_req ? nxt_rdat : 32'h0;
        end
    end

    // configuration writes, low byte then high byte
    // lane 0 carries the code, lane 1 the options;
    // the status word ignores writes
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            code_ff      <= `CFG_CODE_RST;
            pol_ff       <= `CFG_POL_RST;
            mult_ff      <= `CFG_MULT_RST;
            gate_used_ff <= `CFG_GATE_RST;
        end else begin
            if (wr_cfg_b0) begin
                code_ff <= wb_dat_i[`CFG_CODE_MSB:`CFG_CODE_LSB];
            end
            if (wr_cfg_b1) begin
                pol_ff       <= wb_dat_i[`CFG_POL_BIT];
                mult_ff      <= wb_dat_i[`CFG_MULT_MSB:`CFG_MULT_LSB];
                gate_used_ff <= wb_dat_i[`CFG_GATE_BIT];
            end
        end
    end

    // clock level history
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cap_prev_ff <= 1'h0;
            lau_prev_ff <= 1'h0;
        end else begin
            cap_prev_ff <= capture_clk;
            lau_prev_ff <= launch_clk;
        end
    end

    // input flops
    // both loaded every clock; the path mux decides
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            in0_ff <= 1'h0;
            in1_ff <= 1'h0;
        end else begin
            in0_ff <= nxt_in0;
            in1_ff <= nxt_in1;
        end
    end

    // launch flops: first edge takes d0 and enable, second d1
    // the registered enable moves with d0 only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out0_ff   <= 1'h0;
            out1_ff   <= 1'h0;
            oe_reg_ff <= 1'h0;
        end else begin
            if (lau_en0) begin
                out0_ff   <= fabric_i.d_out_0;
                oe_reg_ff <= fabric_i.out_en;
            end
            if (lau_en1) begin
                out1_ff <= fabric_i.d_out_1;
            end
        end
    end

    // ddr phase follows the launch clock, not the gate
    // so the pad never shows a stale half when the
    // gate opens again
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phase_ff <= 1'h0;
        end else if (lau_pri) begin
            phase_ff <= 1'h1;
        end else if (lau_sec) begin
            phase_ff <= 1'h0;
        end
    end

    // pad drivers, floating lanes carry zero
    // lanes past the multiplier stay off
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pad_out_ff <= 3'h0;
            pad_oe_ff  <= 3'h0;
        end else begin
            pad_oe_ff  <= {`PAD_LANES{nxt_drive}} & lane_mask;
            pad_out_ff <= {`PAD_LANES{nxt_data & nxt_drive}} &
                          lane_mask;
        end
    end

    // global buffers for pad input and fabric signal
    // one cycle late, like every other output
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gb_pad_ff <= 1'h0;
            gb_fab_ff <= 1'h0;
        end else begin
            gb_pad_ff <= pad_in;
            gb_fab_ff <= fabric_signal_in;
        end
    end

    // outputs straight from flops
    assign wb_ack_o        = ack_ff;
    assign wb_dat_o        = rdat_ff;
    assign fabric_o.d_in_0 = in0_ff;
    assign fabric_o.d_in_1 = in1_ff;
    assign pad_out         = pad_out_ff;
    assign pad_oe          = pad_oe_ff;
    assign gbuf_pad_out    = gb_pad_ff;
    assign gbuf_fabric_out = gb_fab_ff;
endmodule : configurable_io_cell

// ==== bench/configurable_io_cell_asserts.sv ====
// port checker of the configurable io cell
`include "io_cell_consts.svh"
module io_cell_asserts (
    // system
    input wire logic                         sys_clk,
    input wire logic                         reset,
    // wishbone requests and answer
    input wire logic                         wb_cyc_i,
    input wire logic                         wb_stb_i,
    input wire logic                         wb_we_i,
    input wire logic [`CELL_ADR_W-1:0]       wb_adr_i,
    input wire logic [3:0]                   wb_sel_i,
    input wire logic [31:0]                  wb_dat_i,
    input wire logic                         wb_ack_o,
    // fabric, buffers and pin
    input wire io_cell_pkg::fabric_to_cell_t fabric_i,
    input wire io_cell_pkg::cell_to_fabric_t fabric_o,
    input wire logic                         fabric_signal_in,
    input wire logic                         gbuf_pad_out,
    input wire logic                         gbuf_fabric_out,
    input wire logic                         pad_in,
    input wire logic [`PAD_LANES-1:0]        pad_out,
    input wire logic [`PAD_LANES-1:0]        pad_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import io_cell_pkg::*;
    default clocking dck @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // configuration write taken at this edge
    wire        cfg_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                         && wb_adr_i == `CELL_CFG_OFS && wb_sel_i[0];
    logic [5:0] code_ff;                                // mirrored code
    wire  [5:0] nxt_code = cfg_wr ? wb_dat_i[5:0] : code_ff;
    // follow the function code as software writes it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            code_ff <= `CFG_CODE_RST;
        end else begin
            code_ff <= nxt_code;
        end
    end

    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not a pulse");
    property p_quiet;
        (pad_out & ~pad_oe) == '0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("floating lane");
    property p_nodrive;
        (code_ff[5:2] == 4'h0)[*3] |-> pad_oe == '0;
    endproperty
    a_nodrive: assert property (p_nodrive) else $error("pad driven");
    property p_comb;
        (code_ff[5:2] == 4'h6)[*3]
        |-> pad_oe[0] && pad_out[0] == $past(fabric_i.d_out_0);
    endproperty
    a_comb: assert property (p_comb) else $error("comb out wrong");
    property p_en;
        (code_ff[5:2] == 4'ha)[*3] |-> pad_oe[0] == $past(fabric_i.out_en);
    endproperty
    a_en: assert property (p_en) else $error("enable not followed");
    property p_thru;
        (code_ff[1:0] == 2'h1)[*3] |-> fabric_o.d_in_0 == $past(pad_in);
    endproperty
    a_thru: assert property (p_thru) else $error("input path wrong");
    property p_hold;
        (code_ff[1:0] == 2'h3 && fabric_i.in_hold)[*3]
        |-> $stable(fabric_o.d_in_0);
    endproperty
    a_hold: assert property (p_hold) else $error("held input moved");
    property p_lanes;
        (code_ff[3:2] != 2'h1)[*3] |-> pad_oe[2:1] == 2'h0;
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane replicated");
    property p_gbuf;
        !$past(reset) |-> gbuf_pad_out == $past(pad_in)
            && gbuf_fabric_out == $past(fabric_signal_in);
    endproperty
    a_gbuf: assert property (p_gbuf) else $error("buffer wrong");
    // main scenarios reached
    c_cfg: cover property (cfg_wr);
    c_x3: cover property (pad_oe == 3'h7);
    c_hold: cover property (code_ff[1:0] == 2'h3 && fabric_i.in_hold);
endmodule : io_cell_asserts

bind configurable_io_cell io_cell_asserts u_asserts (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .fabric_i(fabric_i), .fabric_o(fabric_o),
    .fabric_signal_in(fabric_signal_in), .gbuf_pad_out(gbuf_pad_out),
    .gbuf_fabric_out(gbuf_fabric_out), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe)
);

// ==== bench/pad_model.sv ====
// board-side model of the package pin
`include "io_cell_consts.svh"
module pad_model (
    // cell drivers, one per lane
    input  wire logic [`PAD_LANES-1:0] pad_out,
    input  wire logic [`PAD_LANES-1:0] pad_oe,
    // level the board puts on the pin while the cell floats
    input  wire logic                  board_level,
    // resolved pin level
    output logic                       pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    wire driven = |pad_oe;              // any lane driving
    wire level  = |(pad_out & pad_oe);  // value of the driving lanes
    // pin reads back the cell while it drives, else the board
    assign pad_in = driven ? level : board_level;
endmodule : pad_model

// ==== bench/tb_configurable_io_cell.sv ====
// self-checking bench of the configurable io cell
`include "io_cell_consts.svh"
module tb_configurable_io_cell;
    timeunit 1ns;
    timeprecision 1ps;
    import io_cell_pkg::*;
    // clock, reset and bus
    logic                   sys_clk = 1'b0, reset = 1'b1;
    logic                   wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [`CELL_ADR_W-1:0] wb_adr_i = '0;
    logic [3:0]             wb_sel_i = '0;
    logic [31:0]            wb_dat_i = '0, wb_dat_o;
    logic                   wb_ack_o;
    // cell clocks, fabric, buffers and pin
    logic                   capture_clk = 1'b0, launch_clk = 1'b0;
    fabric_to_cell_t        fabric_i = '0;
    cell_to_fabric_t        fabric_o;
    logic                   fabric_signal_in = 1'b0, board_level = 1'b0;
    logic                   gbuf_pad_out, gbuf_fabric_out, pad_in;
    logic [`PAD_LANES-1:0]  pad_out, pad_oe;
    int                     bad_count = 0, checked = 0;
    logic [3:0]             codes [13] = '{4'h0, 4'h6, 4'ha, 4'he, 4'h5,
                                4'h9, 4'hd, 4'h4, 4'h8, 4'hc, 4'h7, 4'hb, 4'hf};

    always #2.5 sys_clk = ~sys_clk;

    configurable_io_cell DUT (.sys_clk(sys_clk), .reset(reset),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .capture_clk(capture_clk), .launch_clk(launch_clk),
        .fabric_i(fabric_i), .fabric_o(fabric_o),
        .fabric_signal_in(fabric_signal_in), .gbuf_pad_out(gbuf_pad_out),
        .gbuf_fabric_out(gbuf_fabric_out), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe));
    pad_model u_pad (.pad_out(pad_out), .pad_oe(pad_oe),
        .board_level(board_level), .pad_in(pad_in));

    // verdict and end of run
    task automatic finish_test;
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    // compare one value
    task automatic check(input string nm, input logic [31:0] exp,
                         input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // one classic wishbone cycle, waits for ack
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] q);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            finish_test();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    // write code byte and option byte
    task automatic cfg(input logic [5:0] c, input logic [7:0] b1);
        logic [31:0] q;
        bus(1'b1, `CELL_CFG_OFS, {16'h0, b1, 2'b00, c}, 4'h3, q);
    endtask : cfg
    task automatic cap(input logic v);
        capture_clk <= v;
        tick(4);
    endtask : cap
    task automatic lch(input logic v);
        launch_clk <= v;
        tick(4);
    endtask : lch
    // reset value, unmapped place, readback
    task automatic t_regs;
        logic [31:0] q;
        bus(1'b1, 8'h08, 32'hffff_ffff, 4'hf, q);
        bus(1'b0, 8'h08, 32'h0, 4'hf, q);
        check("unmapped", 32'h0, q);
        bus(1'b0, `CELL_CFG_OFS, 32'h0, 4'hf, q);
        check("cfg_rst", 32'h0, q);
        cfg(6'h2a, 8'h17);
        bus(1'b0, `CELL_CFG_OFS, 32'h0, 4'hf, q);
        check("cfg_back", 32'h172a, q & 32'h173f);
    endtask : t_regs
    // registered and ddr capture, both polarities
    task automatic t_in;
        cfg(6'h00, 8'h00);
        board_level <= 1'b1;
        cap(1'b1);
        check("rise_in0", 1'b1, fabric_o.d_in_0);
        board_level <= 1'b0;
        tick(4);
        check("kept_in0", 1'b1, fabric_o.d_in_0);
        board_level <= 1'b1;
        cap(1'b0);
        check("fall_in1", 1'b1, fabric_o.d_in_1);
        cfg(6'h00, 8'h01);
        board_level <= 1'b0;
        cap(1'b1);
        check("neg_rise", 2'b10, fabric_o);
        cap(1'b0);
        check("neg_fall", 1'b0, fabric_o.d_in_0);
    endtask : t_in
    // shared gate, used and left open
    task automatic t_gate;
        cfg(6'h00, 8'h10);
        board_level <= 1'b1;
        cap(1'b1);
        check("gated", 1'b0, fabric_o.d_in_0);
        fabric_i.clk_gate <= 1'b1;
        cap(1'b0);
        cap(1'b1);
        check("gate_on", 1'b1, fabric_o.d_in_0);
        cfg(6'h00, 8'h00);
        fabric_i.clk_gate <= 1'b0;
        board_level <= 1'b0;
        cap(1'b0);
        cap(1'b1);
        check("gate_open", 1'b0, fabric_o.d_in_0);
    endtask : t_gate
    // hold on registered and direct inputs
    task automatic t_hold;
        cfg(6'h02, 8'h00);
        board_level <= 1'b1;
        fabric_i.in_hold <= 1'b1;
        cap(1'b0);
        cap(1'b1);
        check("reg_hold", 1'b0, fabric_o.d_in_0);
        fabric_i.in_hold <= 1'b0;
        cap(1'b0);
        cap(1'b1);
        check("reg_free", 1'b1, fabric_o.d_in_0);
        cfg(6'h03, 8'h00);
        board_level <= 1'b0;
        tick(4);
        fabric_i.in_hold <= 1'b1;
        board_level <= 1'b1;
        tick(4);
        check("comb_hold", 1'b0, fabric_o.d_in_0);
        fabric_i.in_hold <= 1'b0;
        tick(4);
        check("comb_free", 1'b1, fabric_o.d_in_0);
        cfg(6'h01, 8'h00);
        board_level <= 1'b0;
        tick(4);
        check("direct", 1'b0, fabric_o.d_in_0);
    endtask : t_hold
    // one output nibble over a launch rise and fall
    task automatic t_out(input logic [3:0] c, input logic en);
        logic oe;
        oe = (c[3:2] == 2'b01) || (c[3:2] != 2'b00 && en);
        fabric_i.d_out_0 <= 1'b1;
        fabric_i.d_out_1 <= 1'b0;
        fabric_i.out_en <= en;
        cfg({c, 2'b00}, 8'h00);
        lch(1'b1);
        check("oe", oe, pad_oe[0]);
        check("out_rise", oe && c[1:0] != 2'b11, pad_out[0]);
        lch(1'b0);
        check("out_fall", oe && c[1] != c[0], pad_out[0]);
    endtask : t_out
    // replicas, and registered data waiting for its edge
    task automatic t_mult;
        logic [31:0] q;
        fabric_i.d_out_0 <= 1'b0;
        cfg(6'h15, 8'h06);
        lch(1'b1);
        lch(1'b0);
        check("x3_oe", 3'h7, pad_oe);
        fabric_i.d_out_0 <= 1'b1;
        tick(4);
        check("no_edge", 3'h0, pad_out);
        lch(1'b1);
        check("x3_out", 3'h7, pad_out);
        bus(1'b0, `CELL_STAT_OFS, 32'h0, 4'hf, q);
        check("status", 32'h3d, q & 32'h3d);
        cfg(6'h15, 8'h04);
        tick(4);
        check("x2_oe", 3'h3, pad_oe);
        cfg(6'h19, 8'h06);
        tick(4);
        check("comb_x1", 3'h1, pad_oe);
        lch(1'b0);
    endtask : t_mult
    // both global buffers
    task automatic t_gbuf;
        cfg(6'h00, 8'h00);
        fabric_signal_in <= 1'b1;
        board_level <= 1'b1;
        tick(2);
        check("gb_fab", 1'b1, gbuf_fabric_out);
        check("gb_pad", 1'b1, gbuf_pad_out);
    endtask : t_gbuf

    // main sequence
    initial begin
        tick(8);
        reset <= 1'b0;
        tick(1);
        t_regs();
        t_in();
        t_gate();
        t_hold();
        foreach (codes[i]) t_out(codes[i], 1'b1);
        t_out(4'ha, 1'b0);
        t_out(4'he, 1'b0);
        t_out(4'h8, 1'b0);
        t_mult();
        t_gbuf();
        finish_test();
    end
    // cut a hang short
    initial begin
        tick(20000);
        bad_count++;
        finish_test();
    end
endmodule : tb_configurable_io_cell
